// [hdl/dcsa_defines.vh]
// register offsets, field positions and codes for the dma channel status arbiter
`ifndef DCSA_DEFINES_VH
`define DCSA_DEFINES_VH
`define DCSA_NCH 4
`define DCSA_OFF_MODE 4'h0
`define DCSA_OFF_BSC 4'h1
`define DCSA_OFF_GLOBAL 4'hF
`define DCSA_ADR_CH_LO 3
`define DCSA_ADR_CH_HI 4
`define DCSA_ADR_REG_LO 2
`define DCSA_ADR_REG_HI 2
`define DCSA_ADR_GLB 5
`define DCSA_B_TEN 0
`define DCSA_B_ACT 1
`define DCSA_B_ERR 2
`define DCSA_B_ESC 3
`define DCSA_B_ESCE 4
`define DCSA_B_END 5
`define DCSA_B_ENDE 6
`define DCSA_B_MODE_LO 8
`define DCSA_B_MODE_HI 9
`define DCSA_B_DUAL 10
`define DCSA_MODE_STEAL 2'h0
`define DCSA_MODE_BURST 2'h1
`define DCSA_MODE_BLOCK 2'h2
`define DCSA_MODE_REPEAT 2'h3
`define DCSA_BURST_TAIL 2'h3
`endif

// [hdl/dcsa_prio.v]
// fixed-priority picker over the channel request lines
module dcsa_prio #(
   parameter NCH = 4
) (
   input wire [NCH-1:0] req_i,
   output reg [NCH-1:0] gnt_o
);
   integer k;
   reg found;
   // lowest index wins
   always @* begin
      gnt_o = {NCH{1'b0}};
      found = 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
         if (req_i[k] && !found) begin
            gnt_o[k] = 1'b1; // [R16]
            found = 1'b1;
         end
      end
   end
endmodule // dcsa_prio

// [hdl/dcsa_bsc.v]
// per-channel block size register: held size and reloading down-counter
module dcsa_bsc (
   input wire clk_i,
   input wire rst_i,
   input wire wr_hi_i,
   input wire wr_lo_i,
   input wire [31:0] wdat_i,
   input wire step_i,
   output reg [31:0] val_o,
   output wire last_o
);
   // last unit of a block when the count stands at one
   assign last_o = (val_o[15:0] == 16'h0001);
   // upper half only changes by software; lower half counts down
   always @(posedge clk_i) begin
      if (rst_i) begin
         val_o <= 32'h00000000;
      end else begin
         if (wr_hi_i) begin
            val_o[31:16] <= wdat_i[31:16]; // [R1] [R3]
         end
         if (wr_lo_i) begin
            val_o[15:0] <= wdat_i[15:0]; // [R3]
         end else if (step_i) begin
            if (last_o) begin
               val_o[15:0] <= val_o[31:16]; // [R2]
            end else begin
               val_o[15:0] <= val_o[15:0] - 16'h0001; // [R1]
            end
         end
      end
   end
endmodule // dcsa_bsc

// [hdl/dcsa_top.v]
// status, counter and arbitration logic of a four-channel dma controller
// Functional notes
// [R1] upper half holds size, lower counts down
// [R2] count reloads from held size, never zero
// [R3] word halves of size register writable separately
// [R4] software leaves size alone while transferring
// [R5] enable cleared on end, errors, reset, write
// [R6] software writes only enable while enabled; the code also takes ESCE, ENDE and the error flag clear then
// [R7] active low when idle or waiting requests
// [R8] block mode finishes whole block after stop
// [R9] burst may do three units after stop
// [R10] abort clears all enables, sets error flag
// [R11] escape conditions set escape flag, interrupt
// [R12] flags set when active drops after cycle
// [R13] re-enable clears escape flag and request
// [R14] transfer end flag set, interrupt when enabled
// [R15] re-enable clears end flag and request
// [R16] channel zero highest, channel three lowest
// [R17] pick best other channel, masters first
// [R18] no switching inside burst or block
// [R19] read and write stay bus-locked together
// [R20] cycle steal releases bus per unit
// [R21] burst runs back to back until end
// [R22] block mode releases bus after block
//
// The address map and the Wishbone register port were decided locally.
`include "dcsa_defines.vh"
module dcsa_top #(
   parameter NCH = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire [31:0] adr_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   input wire we_i,
   input wire [3:0] sel_i,
   input wire cyc_i,
   input wire stb_i,
   output reg ack_o,
   output wire err_o,
   input wire [NCH-1:0] xfer_req_i,
   input wire other_master_req_i,
   input wire unit_done_i,
   input wire total_done_i,
   input wire [NCH-1:0] escape_cond_i,
   input wire nmi_i,
   input wire addr_error_i,
   input wire standby_i,
   output wire [NCH-1:0] grant_o,
   output wire unit_read_o,
   output wire bus_lock_o,
   output wire [NCH-1:0] escape_irq_o,
   output wire [NCH-1:0] transfer_end_irq_o
);
   localparam S_IDLE = 3'b001;
   localparam S_RD = 3'b010;
   localparam S_WR = 3'b100;
   // requests, escapes, other master, nmi, address error, standby synchronised: two flops before use
   reg [NCH-1:0] req_s1_ff, req_s2_ff;
   reg [NCH-1:0] esc_s1_ff, esc_s2_ff;
   reg om_s1_ff, om_s2_ff, nmi_s1_ff, nmi_s2_ff, ae_s1_ff, ae_s2_ff, sb_s1_ff, sb_s2_ff;
   always @(posedge clk_i) begin
      if (rst_i) begin
         req_s1_ff <= {NCH{1'b0}};
         req_s2_ff <= {NCH{1'b0}};
         esc_s1_ff <= {NCH{1'b0}};
         esc_s2_ff <= {NCH{1'b0}};
         {om_s1_ff, om_s2_ff, nmi_s1_ff, nmi_s2_ff} <= 4'h0;
         {ae_s1_ff, ae_s2_ff, sb_s1_ff, sb_s2_ff} <= 4'h0;
      end else begin
         req_s1_ff <= xfer_req_i;
         req_s2_ff <= req_s1_ff;
         esc_s1_ff <= escape_cond_i;
         esc_s2_ff <= esc_s1_ff;
         om_s1_ff <= other_master_req_i;
         om_s2_ff <= om_s1_ff;
         nmi_s1_ff <= nmi_i;
         nmi_s2_ff <= nmi_s1_ff;
         ae_s1_ff <= addr_error_i;
         ae_s2_ff <= ae_s1_ff;
         sb_s1_ff <= standby_i;
         sb_s2_ff <= sb_s1_ff;
      end
   end
   // per-channel mode and status state
   reg [NCH-1:0] ten_ff, act_ff, esc_ff, end_ff, esce_ff, ende_ff, dual_ff, pend_ff;
   reg [1:0] mode_ff [0:NCH-1];
   reg err_ff;
   reg [2:0] st_ff;
   reg [NCH-1:0] cur_ff;
   reg [1:0] tail_ff;
   reg stopped_ff;
   reg [NCH-1:0] escl_ff; // escape condition latched until cycle ends
   reg err_ack_ff;
   // bus slave decode; no new take while either answer stands
   wire acc = cyc_i && stb_i && !ack_o && !err_ack_ff;
   wire glb = adr_i[`DCSA_ADR_GLB];
   wire [1:0] ach = adr_i[`DCSA_ADR_CH_HI:`DCSA_ADR_CH_LO];
   wire areg = adr_i[`DCSA_ADR_REG_HI:`DCSA_ADR_REG_LO];
   wire hit = !glb || (adr_i[5:2] == `DCSA_OFF_GLOBAL);
   wire wr = acc && we_i && hit;
   wire [31:0] bsc_val [0:NCH-1];
   wire [NCH-1:0] bsc_last;
   wire [NCH-1:0] step;
   function is_ch;
      input [1:0] c;
      input [1:0] idx;
      begin
         is_ch = (c == idx);
      end
   endfunction
   // one-cycle ack; unmapped global words answer err
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= acc && hit;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         err_ack_ff <= 1'b0;
      end else begin
         err_ack_ff <= acc && !hit;
      end
   end
   assign err_o = err_ack_ff;
   wire wr_mode = wr && !glb && (areg == 1'b0) && sel_i[0];
   wire abort = nmi_s2_ff || ae_s2_ff;
   // arbitration among pending channels
   wire [NCH-1:0] elig = pend_ff & ten_ff & ~cur_ff;
   wire [NCH-1:0] pick;
   dcsa_prio #(.NCH(NCH)) u_prio (
      .req_i(elig),
      .gnt_o(pick)
   );
   wire [1:0] cmode = (cur_ff[0]) ? mode_ff[0] : (cur_ff[1]) ? mode_ff[1] :
                      (cur_ff[2]) ? mode_ff[2] : mode_ff[3];
   wire cdual = |(cur_ff & dual_ff);
   wire cten = |(cur_ff & ten_ff);
   wire clast = |(cur_ff & bsc_last);
   wire cesc = |(cur_ff & (escl_ff | esc_s2_ff));
   // unit end: write of a dual unit or the single cycle
   wire unit_end = unit_done_i && ((st_ff == S_WR) || ((st_ff == S_RD) && !cdual));
   wire burst_go = cten || (stopped_ff && tail_ff != 2'h0); // [R9]
   wire block_go = (cmode == `DCSA_MODE_BLOCK) && !clast; // [R8]
   wire keep = !total_done_i && !cesc && !abort &&
               (((cmode == `DCSA_MODE_BURST) && burst_go) || block_go);
   assign step = unit_end ? cur_ff : {NCH{1'b0}};
   assign grant_o = cur_ff;
   assign unit_read_o = (st_ff == S_RD);
   assign bus_lock_o = (st_ff == S_WR) || (st_ff == S_RD && cdual); // [R19]
   assign escape_irq_o = esc_ff & esce_ff; // [R11]
   assign transfer_end_irq_o = end_ff & ende_ff; // [R14]
   // transfer sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= S_IDLE;
         cur_ff <= {NCH{1'b0}};
         tail_ff <= 2'h0;
         stopped_ff <= 1'b0;
      end else begin
         case (st_ff)
            S_IDLE: begin
               // other masters get their cycle first
               if (!om_s2_ff && (|pick) && !abort) begin // [R17]
                  cur_ff <= pick; // [R16] [R17]
                  st_ff <= S_RD;
                  stopped_ff <= 1'b0;
               end
            end
            S_RD: begin
               if (unit_done_i) begin
                  if (cdual) begin
                     st_ff <= S_WR; // [R19]
                  end else if (keep) begin
                     st_ff <= S_RD; // [R18] [R21]
                  end else begin
                     st_ff <= S_IDLE; // [R20] [R22]
                     cur_ff <= {NCH{1'b0}};
                  end
               end
            end
            S_WR: begin
               if (unit_done_i) begin
                  if (keep) begin
                     st_ff <= S_RD; // [R18] [R21]
                  end else begin
                     st_ff <= S_IDLE; // [R20] [R22]
                     cur_ff <= {NCH{1'b0}};
                  end
               end
            end
            default: begin
               st_ff <= S_IDLE;
               cur_ff <= {NCH{1'b0}};
            end
         endcase
         // burst tail after a software stop
         if (wr_mode && !dat_i[`DCSA_B_TEN] && (|(cur_ff & (4'h1 << ach))) &&
             (cmode == `DCSA_MODE_BURST) && !stopped_ff) begin
            stopped_ff <= 1'b1;
            tail_ff <= `DCSA_BURST_TAIL; // [R9]
         end else if (unit_end && stopped_ff && tail_ff != 2'h0) begin
            tail_ff <= tail_ff - 2'h1;
         end
      end
   end
   // per-channel status bits and software control
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         wire me_wr = wr_mode && is_ch(ach, g);
         wire mine = cur_ff[g];
         wire fin = mine && unit_end && !keep;
         wire resume = me_wr && dat_i[`DCSA_B_TEN] && !ten_ff[g];
         dcsa_bsc u_bsc (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_hi_i(wr && !glb && is_ch(ach, g) && areg && (sel_i[3] | sel_i[2])),
            .wr_lo_i(wr && !glb && is_ch(ach, g) && areg && (sel_i[1] | sel_i[0])),
            .wdat_i(dat_i),
            .step_i(step[g]),
            .val_o(bsc_val[g]),
            .last_o(bsc_last[g])
         );
         always @(posedge clk_i) begin
            if (rst_i) begin
               ten_ff[g] <= 1'b0; // [R5]
               act_ff[g] <= 1'b0;
               esc_ff[g] <= 1'b0;
               end_ff[g] <= 1'b0;
               esce_ff[g] <= 1'b0;
               ende_ff[g] <= 1'b0;
               dual_ff[g] <= 1'b0;
               pend_ff[g] <= 1'b0;
               escl_ff[g] <= 1'b0;
               mode_ff[g] <= `DCSA_MODE_STEAL;
            end else begin
               if (me_wr) begin
                  esce_ff[g] <= dat_i[`DCSA_B_ESCE];
                  ende_ff[g] <= dat_i[`DCSA_B_ENDE];
                  if (!ten_ff[g]) begin
                     mode_ff[g] <= dat_i[`DCSA_B_MODE_HI:`DCSA_B_MODE_LO]; // [R6]
                     dual_ff[g] <= dat_i[`DCSA_B_DUAL];
                  end
               end
               // enable: end events and aborts win over a software set
               if (abort || sb_s2_ff || (fin && (total_done_i || cesc))) begin
                  ten_ff[g] <= 1'b0; // [R5] [R10]
               end else if (me_wr) begin
                  ten_ff[g] <= dat_i[`DCSA_B_TEN]; // [R5]
               end
               // latch escape condition until the bus cycle completes
               if (mine && esc_s2_ff[g]) begin
                  escl_ff[g] <= 1'b1;
               end else if (fin || !mine) begin
                  escl_ff[g] <= 1'b0;
               end
               // active while owning the bus, incl. stop tails
               if (mine && st_ff != S_IDLE && !fin) begin
                  act_ff[g] <= 1'b1; // [R7] [R8] [R9]
               end else begin
                  act_ff[g] <= 1'b0; // [R7]
               end
               // flags rise as active drops; set wins over clear
               if (fin && cesc) begin
                  esc_ff[g] <= 1'b1; // [R11] [R12]
               end else if (resume) begin
                  esc_ff[g] <= 1'b0; // [R13]
               end
               if (fin && total_done_i) begin
                  end_ff[g] <= 1'b1; // [R12] [R14]
               end else if (resume) begin
                  end_ff[g] <= 1'b0; // [R15]
               end
               // pending request; discarded on resume
               if (resume) begin
                  pend_ff[g] <= 1'b0; // [R13] [R15]
               end else if (req_s2_ff[g] && ten_ff[g]) begin
                  pend_ff[g] <= 1'b1;
               end else if (mine && st_ff == S_IDLE) begin
                  pend_ff[g] <= 1'b0;
               end else if (!ten_ff[g]) begin
                  pend_ff[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate
   // error flag of channel zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         err_ff <= 1'b0;
      end else if (abort) begin
         err_ff <= 1'b1; // [R10]
      end else if (wr_mode && is_ch(ach, 2'h0) && !dat_i[`DCSA_B_ERR]) begin
         err_ff <= 1'b0;
      end
   end
   // read mux, registered
   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (acc && !we_i) begin
         if (glb) begin
            dat_o <= {28'h0000000, act_ff};
         end else if (areg) begin
            dat_o <= bsc_val[ach]; // [R3]
         end else begin
            dat_o <= {21'h000000, dual_ff[ach], mode_ff[ach], 1'b0, ende_ff[ach],
                      end_ff[ach], esce_ff[ach], esc_ff[ach],
                      err_ff & (ach == 2'h0), act_ff[ach], ten_ff[ach]};
         end
      end
   end
endmodule // dcsa_top

// [tb/dcsa_top_monitor.sv]
// port assertions for the dma status arbiter
module dcsa_top_monitor #(
   parameter NCH = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire err_o,
   input wire unit_done_i,
   input wire [NCH-1:0] grant_o,
   input wire unit_read_o,
   input wire bus_lock_o,
   input wire [NCH-1:0] escape_irq_o,
   input wire [NCH-1:0] transfer_end_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // register access: taken request, answer one cycle later
   sequence s_take; cyc_i && stb_i && !ack_o && !err_o; endsequence
   sequence s_answer; ##1 (ack_o || err_o); endsequence
   chk_bus_answer: assert property (s_take |-> s_answer)
      else $error("bus request not answered in one cycle");
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   chk_err_pulse: assert property (err_o |=> !err_o && !ack_o)
      else $error("err held or mixed with ack");
   chk_idle_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
      else $error("answer without request");
   chk_reset_quiet: assert property ($fell(rst_i) |-> grant_o == 0 && !ack_o
      && escape_irq_o == 0 && transfer_end_irq_o == 0)
      else $error("outputs active after reset");
   // arbitration and bus ownership
   chk_grant_onehot: assert property ($onehot0(grant_o))
      else $error("more than one channel granted");
   chk_bus_owner: assert property ((unit_read_o || bus_lock_o) |-> grant_o != 0)
      else $error("bus cycle without owner");
   chk_dual_hold: assert property (unit_read_o && bus_lock_o && unit_done_i
      |=> grant_o != 0 && grant_o == $past(grant_o))
      else $error("bus released between read and write");
   chk_unit_hold: assert property ((grant_o != 0 && !unit_done_i)
      |=> grant_o == $past(grant_o))
      else $error("owner changed inside a bus cycle");
endmodule // dcsa_top_monitor

bind dcsa_top dcsa_top_monitor #(.NCH(NCH)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .unit_done_i(unit_done_i),
   .grant_o(grant_o), .unit_read_o(unit_read_o), .bus_lock_o(bus_lock_o),
   .escape_irq_o(escape_irq_o), .transfer_end_irq_o(transfer_end_irq_o));

// [tb/dcsa_busctl_model.sv]
// bus controller model answering the dma bus cycles
module dcsa_busctl_model (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] grant_i,
   input wire unit_read_i,
   input wire dual_i,
   input wire slow_i,
   input wire [7:0] units_i,
   output reg unit_done_o,
   output wire total_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [1:0] wait_ff;
   reg [7:0] cnt_ff [0:3];
   integer k;
   wire [1:0] ch = {grant_i[3] | grant_i[2], grant_i[3] | grant_i[1]};
   // in dual mode a unit ends on its write cycle
   wire counts = !dual_i || !unit_read_i;
   assign total_done_o = unit_done_o && counts && cnt_ff[ch] == units_i - 8'h01;
   // one bus cycle at a time while a grant stands, prompt or stretched, per-channel unit count
   always @(posedge clk_i) begin
      unit_done_o <= 1'h0;
      if (rst_i) begin
         wait_ff <= 2'h0;
         for (k = 0; k < 4; k++) cnt_ff[k] <= 8'h00;
      end else begin
         if (unit_done_o && counts) cnt_ff[ch] <= total_done_o ? 8'h00 : cnt_ff[ch] + 8'h01;
         if (grant_i != 4'h0 && !unit_done_o) begin
            if (wait_ff >= {slow_i, 1'h0}) begin
               unit_done_o <= 1'h1;
               wait_ff <= 2'h0;
            end else wait_ff <= wait_ff + 2'h1;
         end
      end
   end
endmodule // dcsa_busctl_model

// [tb/tb_top.sv]
// self-checking bench for the dma status arbiter
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
   logic [31:0] adr_i = 32'h0, dat_i = 32'h0;
   logic [3:0] sel_i = 4'h0, xfer_req_i = 4'h0, escape_cond_i = 4'h0, first_gnt = 4'h0;
   logic other_master_req_i = 1'h0, nmi_i = 1'h0, addr_error_i = 1'h0;
   logic dual_i = 1'h0, slow_i = 1'h0, err_seen = 1'h0;
   logic [7:0] units = 8'h01;
   wire [31:0] dat_o;
   wire ack_o, err_o, unit_done_i, total_done_i, unit_read_o, bus_lock_o;
   wire [3:0] grant_o, escape_irq_o, transfer_end_irq_o;
   integer errors = 0, checks_done = 0, seed = 91, i;
   logic [31:0] exp_q[$], msk_q[$];
   initial forever #5 clk_i = ~clk_i;
   dcsa_top #(.NCH(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .err_o(err_o), .xfer_req_i(xfer_req_i), .other_master_req_i(other_master_req_i),
      .unit_done_i(unit_done_i), .total_done_i(total_done_i), .escape_cond_i(escape_cond_i),
      .nmi_i(nmi_i), .addr_error_i(addr_error_i), .standby_i(1'h0), .grant_o(grant_o),
      .unit_read_o(unit_read_o), .bus_lock_o(bus_lock_o), .escape_irq_o(escape_irq_o),
      .transfer_end_irq_o(transfer_end_irq_o));
   dcsa_busctl_model bus_u (.clk_i(clk_i), .rst_i(rst_i), .grant_i(grant_o),
      .unit_read_i(unit_read_o), .dual_i(dual_i), .slow_i(slow_i), .units_i(units),
      .unit_done_o(unit_done_i), .total_done_o(total_done_i));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one classic cycle; a read leaves its expected value for the watcher
   task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, input logic [31:0] m);
      integer n;
      @(posedge clk_i);
      if (!w && m != 32'h0) exp_q.push_back(d & m);
      if (!w && m != 32'h0) msk_q.push_back(m);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      sel_i <= s;
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
      err_seen = err_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      if (n >= 20) begin
         errors++;
         $display("ERROR bus answer expected ack seen none");
         close_out();
      end
   endtask
   task automatic wait_hi(input integer ch, input logic endirq);
      integer n;
      n = 0;
      while ((endirq ? transfer_end_irq_o[ch] : escape_irq_o[ch]) !== 1'h1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 3000) begin
         errors++;
         $display("ERROR irq wait expected 1 seen 0");
         close_out();
      end
   endtask
   // read watcher, other master traffic and first owner capture
   always @(posedge clk_i) begin
      if (ack_o === 1'h1 && we_i === 1'h0 && exp_q.size() > 0) begin
         check("read data", dat_o & msk_q[0], exp_q[0]);
         exp_q.pop_front();
         msk_q.pop_front();
      end
      other_master_req_i <= ($random(seed) & 3) == 0;
      slow_i <= $random(seed) & 1;
      if (first_gnt == 4'h0 && grant_o != 4'h0) first_gnt <= grant_o;
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      errors++;
      $display("ERROR run length expected end seen hang");
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(32'h00, 1'h0, 32'h0, 4'hF, 32'hFFFF_FFFF);
      wb(32'h3C, 1'h0, 32'h0, 4'hF, 32'h0000_000F);
      wb(32'h20, 1'h0, 32'h0, 4'hF, 32'h0);
      check("unmapped err", err_seen, 32'h1);
      $display("test reset done");
      // channels 0 and 2 request together, 0 must win
      wb(32'h00, 1'h1, 32'h0000_0041, 4'hF, 32'h0);
      wb(32'h10, 1'h1, 32'h0000_0041, 4'hF, 32'h0);
      xfer_req_i <= 4'h5;
      wait_hi(0, 1'h1);
      wait_hi(2, 1'h1);
      xfer_req_i <= 4'h0;
      check("first grant", first_gnt, 32'h1);
      wb(32'h00, 1'h0, 32'h0000_0060, 4'hF, 32'h0000_07FF);
      $display("test priority done");
      // every mode on channel 3, two units each
      units <= 8'h02;
      for (i = 0; i < 4; i++) begin
         wb(32'h1C, 1'h1, 32'h0001_0001, 4'hF, 32'h0);
         wb(32'h18, 1'h1, 32'h0000_0041 | (i << 8), 4'hF, 32'h0);
         xfer_req_i <= 4'h8;
         wait_hi(3, 1'h1);
         xfer_req_i <= 4'h0;
         wb(32'h18, 1'h0, 32'h0000_0060 | (i << 8), 4'hF, 32'h0000_07FF);
      end
      $display("test modes done");
      // block mode, dual, word halves written separately
      units <= 8'h04;
      dual_i <= 1'h1;
      wb(32'h0C, 1'h1, 32'h0005_0007, 4'hF, 32'h0);
      wb(32'h0C, 1'h1, 32'h0000_0002, 4'h3, 32'h0);
      wb(32'h0C, 1'h1, 32'h0002_0000, 4'hC, 32'h0);
      wb(32'h0C, 1'h0, 32'h0002_0002, 4'hF, 32'hFFFF_FFFF);
      wb(32'h08, 1'h1, 32'h0000_0641, 4'hF, 32'h0);
      xfer_req_i <= 4'h2;
      wait_hi(1, 1'h1);
      xfer_req_i <= 4'h0;
      wb(32'h0C, 1'h0, 32'h0002_0002, 4'hF, 32'hFFFF_FFFF);
      wb(32'h08, 1'h0, 32'h0000_0660, 4'hF, 32'h0000_07FF);
      wb(32'h08, 1'h1, 32'h0000_0641, 4'hF, 32'h0);
      wb(32'h08, 1'h0, 32'h0000_0001, 4'hF, 32'h0000_0023);
      check("end irq", transfer_end_irq_o[1], 32'h0);
      wb(32'h08, 1'h1, 32'h0, 4'hF, 32'h0);
      dual_i <= 1'h0;
      $display("test block done");
      // nmi then address error clear enables and set the error flag
      for (i = 0; i < 2; i++) begin
         wb(32'h18, 1'h1, 32'h0000_0001, 4'hF, 32'h0);
         if (i == 0) nmi_i <= 1'h1;
         else addr_error_i <= 1'h1;
         repeat (4) @(posedge clk_i);
         nmi_i <= 1'h0;
         addr_error_i <= 1'h0;
         repeat (4) @(posedge clk_i);
         wb(32'h00, 1'h0, 32'h0000_0004, 4'hF, 32'h0000_0004);
         wb(32'h18, 1'h0, 32'h0, 4'hF, 32'h0000_0001);
         wb(32'h00, 1'h1, 32'h0, 4'hF, 32'h0);
      end
      $display("test abort done");
      // escape condition, interrupt, then resume clears it
      // burst on channel 3 gives up the bus at its first unit end while the condition stands
      units <= 8'h40;
      wb(32'h18, 1'h1, 32'h0000_0111, 4'hF, 32'h0);
      escape_cond_i <= 4'h8;
      xfer_req_i <= 4'h8;
      wait_hi(3, 1'h0);
      escape_cond_i <= 4'h0;
      xfer_req_i <= 4'h0;
      wb(32'h18, 1'h0, 32'h0000_0008, 4'hF, 32'h0000_0009);
      wb(32'h18, 1'h1, 32'h0000_0011, 4'hF, 32'h0);
      check("escape irq", escape_irq_o[3], 32'h0);
      wb(32'h18, 1'h1, 32'h0, 4'hF, 32'h0);
      $display("test escape done");
      close_out();
   end
endmodule // tb_top
